/* File: isc_cmd_eng.sv */
// Read transaction engine: sends command bits as long/short pulses,
// then collects sixteen data bits and a parity bit from the sensor.
`timescale 1ns/1ps
module isc_cmd_eng (
    // Clock and control
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Transaction port
    isc_cmd_if.eng    bus
);
    isc_pkg::isc_state_t state, next_state;
    logic [4:0]  bitcnt, next_bitcnt;
    logic        aligned, next_aligned;
    logic [5:0]  txsh, next_txsh;
    logic [16:0] rxsh, next_rxsh;

    // ************************************************
    // Sequencer
    // ************************************************
    // First tick only aligns, since the period in flight predates start
    always_comb begin
        next_state   = state;
        next_bitcnt  = bitcnt;
        next_aligned = aligned;
        next_txsh    = txsh;
        next_rxsh    = rxsh;
        case (state)
            isc_pkg::ISC_IDLE: begin
                if (bus.start) begin
                    next_state   = isc_pkg::ISC_SEND;
                    next_txsh    = {bus.cmd, bus.sel};
                    next_bitcnt  = '0;
                    next_aligned = 1'b0;
                end
            end
            isc_pkg::ISC_SEND: begin
                if (bus.tick) begin
                    if (!aligned) begin
                        next_aligned = 1'b1;
                    end else begin
                        next_txsh   = {txsh[4:0], 1'b0};
                        next_bitcnt = bitcnt + 1'b1;
                        if (bitcnt == 5'(isc_pkg::TX_BITS - 1)) begin
                            next_state  = isc_pkg::ISC_RECV;
                            next_bitcnt = '0;
                        end
                    end
                end
            end
            isc_pkg::ISC_RECV: begin
                if (bus.tick) begin
                    next_rxsh   = {rxsh[15:0], bus.rx};
                    next_bitcnt = bitcnt + 1'b1;
                    if (bitcnt == 5'(isc_pkg::RX_BITS - 1)) begin
                        next_state = isc_pkg::ISC_DONE;
                    end
                end
            end
            isc_pkg::ISC_DONE: next_state = isc_pkg::ISC_IDLE;
            default:           next_state = isc_pkg::ISC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= isc_pkg::ISC_IDLE;
            bitcnt  <= '0;
            aligned <= 1'b0;
            txsh    <= '0;
            rxsh    <= '0;
        end else if (ce) begin
            state   <= next_state;
            bitcnt  <= next_bitcnt;
            aligned <= next_aligned;
            txsh    <= next_txsh;
            rxsh    <= next_rxsh;
        end
    end

    // Outputs decoded from state flops and the two shift registers
    assign bus.busy     = (state != isc_pkg::ISC_IDLE);
    assign bus.done     = (state == isc_pkg::ISC_DONE);
    assign bus.send     = (state == isc_pkg::ISC_SEND) && aligned;
    assign bus.long_bit = txsh[5];
    assign bus.result   = rxsh[16:1];
    assign bus.perr     = ^rxsh; // even parity over data and check bit
endmodule

/* File: isc_cmd_if.sv */
// Interface between the controller top and its read transaction engine.
// Assumes one clock domain; all members are driven by flops or decode.
`timescale 1ns/1ps
interface isc_cmd_if;
    logic        start;
    logic [2:0]  cmd;
    logic [2:0]  sel;
    logic        tick;
    logic        rx;
    logic        busy;
    logic        done;
    logic        send;
    logic        long_bit;
    logic [15:0] result;
    logic        perr;

    modport eng (input start, cmd, sel, tick, rx,
                 output busy, done, send, long_bit, result, perr);
    modport ctl (output start, cmd, sel, tick, rx,
                 input busy, done, send, long_bit, result, perr);
endinterface

/* File: isc_ctrl.sv */
// Top of the isolated sensor command controller: MPU byte registers,
// three sensor links and the compute RAM write port.
// Assumes link input pins are asynchronous to MCLK.
`timescale 1ns/1ps
module isc_ctrl #(
    parameter int DECIM_LEN = 64
) (
    // Clock, reset, enable
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    input  wire logic        CE,
    // Special-function register port
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WE,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    // I/O RAM register port
    input  wire logic [15:0] IO_ADDR,
    input  wire logic        IO_WE,
    input  wire logic [7:0]  IO_WDATA,
    output logic      [7:0]  IO_RDATA,
    // Sensor link pins, index 0..2 = pairs a, b, c
    output logic      [2:0]  LINK_TX_O,
    output logic      [2:0]  LINK_TX_OE,
    input  wire logic [2:0]  LINK_RX_I,
    // Compute RAM write port
    output logic             CE_RAM_WE,
    output logic      [7:0]  CE_RAM_ADDR,
    output logic      [31:0] CE_RAM_WDATA
);
    localparam int SUM_W = $clog2(DECIM_LEN) + 1;

    logic rst_meta, rst_n;
    logic [2:0] rx_meta, rx_sync;

    // ************************************************
    // Reset release and pin synchronisers
    // ************************************************
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Two stages before any logic reads the sensor line
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta <= 3'h0;
            rx_sync <= 3'h0;
        end else if (CE) begin
            rx_meta <= LINK_RX_I;
            rx_sync <= rx_meta;
        end
    end

    // ************************************************
    // Links
    // ************************************************
    isc_cmd_if cmd_if ();

    logic [2:0]       link_en;
    logic [2:0]       tick, dec_valid, long_req;
    logic [SUM_W-1:0] dec_sum [3];
    logic [1:0]       act_link;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_link
            // Command bits ride on pulse width only toward the active link
            assign long_req[i] = cmd_if.send && cmd_if.long_bit && (act_link == 2'(i + 1));
            isc_link #(
                .DECIM_LEN (DECIM_LEN),
                .SUM_W     (SUM_W)
            ) u_link (
                .clk       (MCLK),
                .rst_n     (rst_n),
                .ce        (CE),
                .enable    (link_en[i]),
                .long_req  (long_req[i]),
                .rx        (rx_sync[i]),
                .pulse_o   (LINK_TX_O[i]),
                .pulse_oe  (LINK_TX_OE[i]),
                .tick      (tick[i]),
                .dec_valid (dec_valid[i]),
                .dec_sum   (dec_sum[i])
            );
        end
    endgenerate

    isc_cmd_eng u_eng (
        .clk   (MCLK),
        .rst_n (rst_n),
        .ce    (CE),
        .bus   (cmd_if.eng)
    );

    // ************************************************
    // Registers
    // ************************************************
    logic [4:0]  sensor_command_field, next_sensor_command_field;
    logic        read_parity_error, next_read_parity_error;
    logic [2:0]  sel_a, sel_b, sel_c, next_sel_a, next_sel_b, next_sel_c;
    logic [2:0]  next_link_en;
    logic [1:0]  chop, next_chop, next_act_link;
    logic [15:0] rdbuf, next_rdbuf;
    logic [7:0]  next_sfr_rdata, next_io_rdata;
    logic        cmd_wr, launch;
    logic [2:0]  wr_cmd, pick_sel;
    logic [1:0]  wr_phase;

    // Command write decode; fields split as code and phase
    assign cmd_wr   = SFR_WE && (SFR_ADDR == isc_pkg::SFR_CMD_ADDR);
    assign wr_cmd   = SFR_WDATA[4:2];
    assign wr_phase = SFR_WDATA[1:0];

    // Phase picks the link and its select field
    always_comb begin
        case (wr_phase)
            2'h1:    pick_sel = sel_a;
            2'h2:    pick_sel = sel_b;
            2'h3:    pick_sel = sel_c;
            default: pick_sel = 3'h0;
        endcase
    end

    // Invalid codes, phase 00, a disabled link or a busy engine never launch
    assign launch = cmd_wr && !cmd_if.busy
                 && (wr_cmd != isc_pkg::CMD_NONE) && (wr_cmd != isc_pkg::CMD_INVALID)
                 && (wr_phase != isc_pkg::PHASE_NONE)
                 && link_en[wr_phase - 2'h1];
    assign cmd_if.start = launch;
    assign cmd_if.cmd   = wr_cmd;
    assign cmd_if.sel   = pick_sel;
    assign cmd_if.tick  = (act_link == 2'h0) ? 1'b0 : tick[act_link - 2'h1];
    assign cmd_if.rx    = (act_link == 2'h0) ? 1'b0 : rx_sync[act_link - 2'h1];

    // Next register values; hardware set beats software clear
    always_comb begin
        next_sensor_command_field = sensor_command_field;
        next_read_parity_error    = read_parity_error;
        next_sel_a    = sel_a;
        next_sel_b    = sel_b;
        next_sel_c    = sel_c;
        next_link_en  = link_en;
        next_chop     = chop;
        next_rdbuf    = rdbuf;
        next_act_link = act_link;
        if (cmd_wr) begin
            if (!SFR_WDATA[isc_pkg::RD_PARITY_BIT]) begin
                next_read_parity_error = 1'b0;
            end
            if (launch) begin
                next_sensor_command_field = SFR_WDATA[4:0];
                next_act_link             = wr_phase;
            end else if (!cmd_if.busy) begin
                next_sensor_command_field = {isc_pkg::CMD_NONE, wr_phase};
            end
        end
        if (cmd_if.done) begin
            next_sensor_command_field[4:2] = isc_pkg::CMD_NONE;
            next_rdbuf                     = cmd_if.result;
            next_act_link                  = 2'h0;
            if (cmd_if.perr) begin
                next_read_parity_error = 1'b1;
            end
        end
        if (IO_WE && IO_ADDR == isc_pkg::IO_SEL_AB) begin
            next_sel_a = IO_WDATA[isc_pkg::SEL_A_LSB +: 3];
            next_sel_b = IO_WDATA[isc_pkg::SEL_B_LSB +: 3];
        end
        if (IO_WE && IO_ADDR == isc_pkg::IO_SEL_C) begin
            next_sel_c   = IO_WDATA[isc_pkg::SEL_C_LSB +: 3];
            next_link_en = IO_WDATA[isc_pkg::EN_LSB +: 3];
            next_chop    = IO_WDATA[isc_pkg::CHOP_LSB +: 2];
        end
    end

    // Read data, one cycle after the address
    always_comb begin
        next_sfr_rdata = isc_pkg::RST_BYTE;
        if (SFR_ADDR == isc_pkg::SFR_CMD_ADDR) begin
            next_sfr_rdata = {1'b0, read_parity_error, 1'b0, sensor_command_field};
        end
        case (IO_ADDR)
            isc_pkg::IO_RDBUF_HI: next_io_rdata = rdbuf[15:8];
            isc_pkg::IO_RDBUF_LO: next_io_rdata = rdbuf[7:0];
            isc_pkg::IO_SEL_C:    next_io_rdata = {chop, link_en, sel_c};
            isc_pkg::IO_SEL_AB:   next_io_rdata = {1'b0, sel_b, 1'b0, sel_a};
            default:              next_io_rdata = isc_pkg::RST_BYTE;
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            sensor_command_field <= 5'h00;
            read_parity_error    <= 1'b0;
            sel_a     <= 3'h0;
            sel_b     <= 3'h0;
            sel_c     <= 3'h0;
            link_en   <= 3'h0;
            chop      <= 2'h0;
            rdbuf     <= isc_pkg::RST_WORD;
            act_link  <= 2'h0;
            SFR_RDATA <= isc_pkg::RST_BYTE;
            IO_RDATA  <= isc_pkg::RST_BYTE;
        end else if (CE) begin
            sensor_command_field <= next_sensor_command_field;
            read_parity_error    <= next_read_parity_error;
            sel_a     <= next_sel_a;
            sel_b     <= next_sel_b;
            sel_c     <= next_sel_c;
            link_en   <= next_link_en;
            chop      <= next_chop;
            rdbuf     <= next_rdbuf;
            act_link  <= next_act_link;
            SFR_RDATA <= next_sfr_rdata;
            IO_RDATA  <= next_io_rdata;
        end
    end

    // ************************************************
    // Compute RAM writer
    // ************************************************
    logic [2:0]       pend, next_pend, grant;
    logic [SUM_W-1:0] hold [3];
    logic [SUM_W-1:0] next_hold [3];
    logic             next_we;
    logic [7:0]       next_addr;
    logic [31:0]      next_wdata;

    // Lowest pending link wins; one slot per cycle is far above stream rate
    always_comb begin
        next_pend  = pend;
        next_hold  = hold;
        next_we    = 1'b0;
        next_addr  = CE_RAM_ADDR;
        next_wdata = CE_RAM_WDATA;
        grant      = pend & ~(pend - 3'h1);
        for (int i = 0; i < 3; i++) begin
            if (grant[i]) begin
                next_we      = 1'b1;
                next_addr    = isc_pkg::CE_SLOT_BASE + 8'(i);
                next_wdata   = 32'(hold[i]);
                next_pend[i] = 1'b0;
            end
            if (dec_valid[i] && link_en[i]) begin
                next_pend[i] = 1'b1;
                next_hold[i] = dec_sum[i];
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pend         <= 3'h0;
            hold         <= '{default: '0};
            CE_RAM_WE    <= 1'b0;
            CE_RAM_ADDR  <= 8'h00;
            CE_RAM_WDATA <= 32'h0000_0000;
        end else if (CE) begin
            pend         <= next_pend;
            hold         <= next_hold;
            CE_RAM_WE    <= next_we;
            CE_RAM_ADDR  <= next_addr;
            CE_RAM_WDATA <= next_wdata;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    busy_ignore_a: assert property (CE && cmd_wr && cmd_if.busy && !cmd_if.done
        |=> sensor_command_field == $past(sensor_command_field))
        else $error("command accepted while busy");
    launch_busy_a: assert property (CE && launch
        |=> cmd_if.busy && sensor_command_field[4:2] == $past(wr_cmd))
        else $error("launch did not start engine");
    done_clear_a: assert property (CE && cmd_if.done
        |=> sensor_command_field[4:2] == 3'h0 && rdbuf == $past(cmd_if.result))
        else $error("completion wrong");
    perr_set_a: assert property (CE && cmd_if.done && cmd_if.perr |=> read_parity_error)
        else $error("parity error not flagged");
    perr_hold_a: assert property (CE && read_parity_error && !cmd_wr |=> read_parity_error)
        else $error("parity flag dropped");
    phase_sel_a: assert property (CE && launch && wr_phase == 2'h2
        |=> act_link == 2'h2 && u_eng.txsh[2:0] == $past(sel_b))
        else $error("wrong select field");
    sel_write_a: assert property (CE && IO_WE && IO_ADDR == isc_pkg::IO_SEL_AB
        |=> sel_b == $past(IO_WDATA[6:4])) else $error("select field not stored");
    buf_read_a: assert property (CE && IO_ADDR == isc_pkg::IO_RDBUF_HI
        |=> IO_RDATA == $past(rdbuf[15:8])) else $error("buffer high byte wrong");
    link_oe_a: assert property (CE && link_en[1] |=> LINK_TX_OE[1])
        else $error("pin pair not driven");
    dec_pend_a: assert property (CE && dec_valid[0] && link_en[0] |=> pend[0])
        else $error("decimated sample lost");

    launch_c: cover property (CE && launch);
    done_c:   cover property (CE && cmd_if.done);
    perr_c:   cover property (CE && cmd_if.done && cmd_if.perr);
    ram_c:    cover property (CE_RAM_WE);
endmodule

/* File: isc_link.sv */
// One sensor link: power pulse generator and modulator decimator.
// Assumes rx is already synchronised to clk.
`timescale 1ns/1ps
module isc_link #(
    parameter int DECIM_LEN = 64,
    parameter int SUM_W     = 7
) (
    // Clock and control
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             enable,
    input  wire logic             long_req,
    input  wire logic             rx,
    // Pin drive and stream results
    output logic                  pulse_o,
    output logic                  pulse_oe,
    output logic                  tick,
    output logic                  dec_valid,
    output logic [SUM_W-1:0]      dec_sum
);
    localparam int PW = $clog2(isc_pkg::PULSE_CYC);
    localparam int DW = $clog2(DECIM_LEN);

    logic [PW-1:0]    cnt, next_cnt;
    logic             long_q, next_long_q;
    logic [DW-1:0]    dcnt, next_dcnt;
    logic [SUM_W-1:0] acc, next_acc, next_dec_sum;
    logic             next_pulse_o, next_tick, next_dec_valid;

    // ************************************************
    // Pulse timing and decimation
    // ************************************************
    // Free-running period keeps the sensor converter clock steady
    always_comb begin
        next_cnt       = cnt;
        next_long_q    = long_q;
        next_tick      = 1'b0;
        next_dcnt      = dcnt;
        next_acc       = acc;
        next_dec_sum   = dec_sum;
        next_dec_valid = 1'b0;
        next_pulse_o   = 1'b0;
        if (enable) begin
            next_cnt = (cnt == PW'(isc_pkg::PULSE_CYC - 1)) ? '0 : cnt + 1'b1;
            if (cnt == '0) begin
                next_long_q = long_req;
            end
            next_tick    = (cnt == PW'(isc_pkg::PULSE_CYC - 1));
            next_pulse_o = long_q ? (cnt < PW'(isc_pkg::LONG_CYC))
                                  : (cnt < PW'(isc_pkg::SHORT_CYC));
            if (tick) begin
                next_acc  = acc + SUM_W'(rx);
                next_dcnt = dcnt + 1'b1;
                if (dcnt == DW'(DECIM_LEN - 1)) begin
                    next_dec_sum   = acc + SUM_W'(rx);
                    next_dec_valid = 1'b1;
                    next_acc       = '0;
                    next_dcnt      = '0;
                end
            end
        end else begin
            next_cnt  = '0;
            next_acc  = '0;
            next_dcnt = '0;
        end
    end

    // Register stage, frozen by ce
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt       <= '0;
            long_q    <= 1'b0;
            tick      <= 1'b0;
            dcnt      <= '0;
            acc       <= '0;
            dec_sum   <= '0;
            dec_valid <= 1'b0;
            pulse_o   <= 1'b0;
            pulse_oe  <= 1'b0;
        end else if (ce) begin
            cnt       <= next_cnt;
            long_q    <= next_long_q;
            tick      <= next_tick;
            dcnt      <= next_dcnt;
            acc       <= next_acc;
            dec_sum   <= next_dec_sum;
            dec_valid <= next_dec_valid;
            pulse_o   <= next_pulse_o;
            pulse_oe  <= enable;
        end
    end

    pulse_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && enable && tick) |=> ($past(ce) && cnt == PW'(1)) || !$past(ce))
        else $error("pulse period broken");
endmodule

/* File: isc_pkg.sv */
// Constants shared by the isolated sensor command controller files.
// Assumes a single 100 MHz system clock and byte-wide MPU register ports.
// Operation
// - Link enable turns pin pair digital
// - Decimate each enabled stream into compute RAM
// - Power pulses run continuously and regularly
// - Command code plus link select pick item
// - Three select fields at fixed byte positions
// - Command field write launches sensor read
// - Bits 4:2 command, bits 1:0 phase
// - Completion clears command bits, buffer valid
// - Buffer high byte 0x2602, low 0x2603
// - Parity error flag set by any read with bad parity
// - Command write while busy is ignored, except bit 6 low still clears the parity flag
// - Parity flags sticky until processor clears
package isc_pkg;

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0]  SFR_CMD_ADDR = 8'hFC;
    localparam logic [15:0] IO_RDBUF_HI  = 16'h2602;
    localparam logic [15:0] IO_RDBUF_LO  = 16'h2603;
    localparam logic [15:0] IO_SEL_C     = 16'h2709;
    localparam logic [15:0] IO_SEL_AB    = 16'h270A;

    // Field positions
    localparam int RD_PARITY_BIT = 6;
    localparam int SEL_A_LSB   = 0;
    localparam int SEL_B_LSB   = 4;
    localparam int SEL_C_LSB   = 0;
    localparam int EN_LSB      = 3;
    localparam int CHOP_LSB    = 6;

    // Codes and reset values
    localparam logic [2:0]  CMD_NONE    = 3'h0;
    localparam logic [2:0]  CMD_INVALID = 3'h5;
    localparam logic [1:0]  PHASE_NONE  = 2'h0;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [7:0]  CE_SLOT_BASE = 8'h00;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PULSE_PERIOD_NS = 160;
    localparam int SHORT_HIGH_NS   = 40;
    localparam int LONG_HIGH_NS    = 80;
    localparam int PULSE_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SHORT_CYC = SHORT_HIGH_NS / CLK_PERIOD_NS;
    localparam int LONG_CYC  = LONG_HIGH_NS / CLK_PERIOD_NS;
    localparam int TX_BITS   = 6;
    localparam int RX_BITS   = 17;

    typedef enum logic [1:0] {
        ISC_IDLE = 2'b00,
        ISC_SEND = 2'b01,
        ISC_RECV = 2'b11,
        ISC_DONE = 2'b10
    } isc_state_t;

endpackage

/* File: isc_sensor_model.sv */
// Behavioural isolated sensor: answers every bit period with one level.
// Assumes MCLK at 100 MHz and one model per link pin pair.
`timescale 1ns/1ps
module isc_sensor_model (
    // Clock and link pins
    input  wire logic clk,
    input  wire logic tx,
    input  wire logic oe,
    input  wire logic level,
    output logic      rx,
    // Pulse timing faults and long pulses seen
    output int        faults,
    output int        longs
);
    int   per = 0;
    int   hi = 0;
    logic tx_d = 0;
    logic flip = 0;
    initial faults = 0;
    initial longs = 0;
    // Released line toggles so a stale level never passes for data
    assign rx = oe ? level : flip;
    // Power must be regular: 16-cycle period, 4 or 8 cycles high
    always @(posedge clk) begin
        flip <= ~flip;
        tx_d <= tx;
        per  <= !oe ? 0 : (tx && !tx_d) ? 1 : per + 1;
        hi   <= tx ? hi + 1 : 0;
        if (oe && tx && !tx_d && per != 0 && per != 16)
            faults <= faults + 1;
        if (oe && !tx && tx_d && hi != 4 && hi != 8)
            faults <= faults + 1;
        // One long pulse per command bit that is one
        if (oe && !tx && tx_d && hi == 8)
            longs <= longs + 1;
    end
endmodule

/* File: isolated_sensor_command_ctrl_test.sv */
// Testbench for the sensor command controller through its byte ports.
// Assumes one sensor model per link, each answering a fixed level.
`timescale 1ns/1ps
module isolated_sensor_command_ctrl_test;
    localparam int DL = 8;
    logic        MCLK, RST_B, SFR_WE, IO_WE, CE_RAM_WE;
    logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA, IO_WDATA, IO_RDATA, CE_RAM_ADDR, rv;
    logic [15:0] IO_ADDR;
    logic [2:0]  LINK_TX_O, LINK_TX_OE, LINK_RX_I;
    logic [31:0] CE_RAM_WDATA;
    logic [2:0]  lv = 3'b101;
    logic        CE = 1'b1;
    int          err_total = 0, check_count = 0, flt [3], lng [3];

    isc_ctrl #(.DECIM_LEN(DL)) dut (.MCLK(MCLK), .RST_B(RST_B), .CE(CE),
        .SFR_ADDR(SFR_ADDR), .SFR_WE(SFR_WE), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
        .IO_ADDR(IO_ADDR), .IO_WE(IO_WE), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
        .LINK_TX_O(LINK_TX_O), .LINK_TX_OE(LINK_TX_OE), .LINK_RX_I(LINK_RX_I),
        .CE_RAM_WE(CE_RAM_WE), .CE_RAM_ADDR(CE_RAM_ADDR), .CE_RAM_WDATA(CE_RAM_WDATA));
    for (genvar i = 0; i < 3; i++) begin : g_snr
        isc_sensor_model snr (.clk(MCLK), .tx(LINK_TX_O[i]), .oe(LINK_TX_OE[i]),
                              .level(lv[i]), .rx(LINK_RX_I[i]), .faults(flt[i]),
                              .longs(lng[i]));
    end
    // 100 MHz clock
    initial begin
        MCLK = 0;
        forever #5 MCLK = ~MCLK;
    end
    task automatic test_done;
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge MCLK);
        #1;
    endtask
    // A used-up wait ends the run at once
    task automatic guard(input int n);
        if (n >= 3000) begin
            err_total++;
            test_done;
        end
    endtask
    // Idle cycle after each write keeps strobes from being driven twice
    task automatic wr(input logic io, input logic [15:0] a, input logic [7:0] d);
        {IO_ADDR, IO_WDATA, IO_WE, SFR_ADDR, SFR_WDATA, SFR_WE} = {a, d, io, a[7:0], d, !io};
        step;
        {IO_WE, SFR_WE} = 2'b00;
        step;
    endtask
    task automatic rd(input logic io, input logic [15:0] a);
        {IO_ADDR, SFR_ADDR} = {a, a[7:0]};
        step;
        rv = io ? IO_RDATA : SFR_RDATA;
    endtask
    task automatic wait_idle;
        int n = 0;
        do begin
            rd(0, 16'h00FC);
            n++;
        end while (rv[4:2] !== 3'h0 && n < 3000);
        guard(n);
    endtask
    task automatic dec_chk(input logic [7:0] a, input logic [31:0] exp);
        int n = 0;
        int k = 0;
        while (k < 2 && n < 3000) begin
            step;
            n++;
            if (CE_RAM_WE === 1'b1 && CE_RAM_ADDR === a) k++;
        end
        guard(n);
        chk(CE_RAM_WDATA, exp);
    endtask
    // Main sequence
    initial begin
        RST_B = 0;
        {IO_ADDR, IO_WDATA, IO_WE, SFR_ADDR, SFR_WDATA, SFR_WE} = '0;
        repeat (4) @(posedge MCLK);
        #1 RST_B = 1;
        repeat (3) step;
        rd(0, 16'h00FC);
        chk(rv, 8'h00);
        rd(1, 16'h2602);
        chk(rv, 8'h00);
        chk(LINK_TX_OE, 3'h0);
        wr(1, 16'h270A, 8'hFF);
        wr(1, 16'h2709, 8'hFF);
        rd(1, 16'h270A);
        chk(rv, 8'h77);
        rd(1, 16'h2709);
        chk(rv, 8'hFF);
        chk(LINK_TX_OE, 3'h7);
        for (int i = 0; i < 3; i++) dec_chk(i[7:0], lv[i] ? DL : 0);
        // Each phase reads its own link; a second write while busy is dropped
        for (int p = 1; p <= 3; p++) begin
            wr(0, 16'h00FC, {6'h01, p[1:0]});
            wr(0, 16'h00FC, {6'h02, p[1:0]});
            rd(0, 16'h00FC);
            chk(rv, {6'h01, p[1:0]});
            wait_idle;
            chk(rv, {1'b0, lv[p-1], 4'h0, p[1:0]});
            // Code 001 and select 111 carry four ones, only toward this link
            chk(lng[p-1], 4);
            chk(lng[0] + lng[1] + lng[2], 4 * p);
            rd(1, 16'h2602);
            chk(rv, {8{lv[p-1]}});
            rd(1, 16'h2603);
            chk(rv, {8{lv[p-1]}});
        end
        wr(0, 16'h00FC, 8'h4A);
        wait_idle;
        chk(rv, 8'h42);
        wr(0, 16'h00FC, 8'h00);
        rd(0, 16'h00FC);
        chk(rv, 8'h00);
        wr(0, 16'h00FC, 8'h15);
        rd(0, 16'h00FC);
        chk(rv, 8'h01);
        wr(1, 16'h2602, 8'hAA);
        rd(1, 16'h2602);
        chk(rv, 8'h00);
        chk(flt[0] + flt[1] + flt[2], 0);
        // Enable low freezes the registers against a write
        CE = 1'b0;
        wr(1, 16'h270A, 8'h00);
        CE = 1'b1;
        rd(1, 16'h270A);
        chk(rv, 8'h77);
        test_done;
    end
endmodule
